/* hw/hmap_defines.svh */
// Purpose: shared offsets, field positions and codes of the host memory access port
// Assumes: included by its bare name from every design file that needs it
// Notes: definitions only
`ifndef HMAP_DEFINES_SVH
`define HMAP_DEFINES_SVH

// processor-side register map, data memory space word addresses
`define HMAP_START_ADDR_OFS 14'h3fe0
`define HMAP_OVERLAY_OFS 14'h3fe7
// first memory-mapped control register; host writes at or above it are dropped
`define HMAP_CTRL_BASE 14'h3fe0

// start address register fields
`define HMAP_ADDR_MSB 13
`define HMAP_DEST_BIT 14
`define HMAP_LATCH_FLAG_BIT 15
`define HMAP_DEST_PM 1'b0

// boot mode pins {c, b, a} that select booting through the port
`define HMAP_BOOT_PORT 3'h5

// host controller registers on its plain user port
`define HREG_ADDR 2'h0
`define HREG_DATA 2'h1
`define HREG_CMD 2'h2
`define HREG_STAT 2'h3
`define HREG_CMD_READ_BIT 0
`define HREG_STAT_BUSY_BIT 0
`define HREG_STAT_FULL_BIT 1
`define HREG_STAT_EMPTY_BIT 2
`define HREG_STAT_ACK_BIT 3

`endif

/* hw/hmap_pkg.sv */
// Purpose: types shared by both ends of the host memory access port
// Assumes: nothing
// Notes: numbers live in hmap_defines.svh
package hmap_pkg;
	typedef logic [15:0] bus_word_t;
	typedef logic [23:0] pm_word_t;
	typedef enum logic [2:0] {D_IDLE, D_LATCH, D_SYNC, D_ACCESS, D_HOLD} dev_state_e;
	typedef enum logic [2:0] {H_IDLE, H_ALE_HI, H_ALE_LO, H_XFER, H_WAIT} host_state_e;
endpackage

/* hw/hmap_if.sv */
// Purpose: pins between host and device of the host memory access port
// Assumes: strobes active low except the latch enable, which is active high
// Notes: resolves the shared 16-bit bus; an undriven bus reads all ones (pull-ups)
interface hmap_if;
	logic port_select_b;
	logic address_latch_enable;
	logic port_read_strobe_b;
	logic port_write_strobe_b;
	logic access_acknowledge;
	hmap_pkg::bus_word_t host_ad;
	logic host_ad_oe;
	hmap_pkg::bus_word_t dev_ad;
	logic dev_ad_oe;
	hmap_pkg::bus_word_t multiplexed_addr_data_bus;

	// wire level worked out from the two enables
	assign multiplexed_addr_data_bus = host_ad_oe ? host_ad : (dev_ad_oe ? dev_ad : 16'hffff);

	modport device (input port_select_b, input address_latch_enable, input port_read_strobe_b,
		input port_write_strobe_b, input multiplexed_addr_data_bus, output dev_ad, output dev_ad_oe,
		output access_acknowledge);
	modport host (output port_select_b, output address_latch_enable, output port_read_strobe_b,
		output port_write_strobe_b, output host_ad, output host_ad_oe, input multiplexed_addr_data_bus,
		input access_acknowledge);
endinterface

/* hw/word_fifo.sv */
// Purpose: small flip-flop FIFO with valid and ready on both sides
// Assumes: one clock; push and pop may happen in the same cycle
// Notes: ready and valid come from flops so nothing combinational leaks to ports
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2) begin : g_bad_depth
		$error("word_fifo depth must be at least two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic push;
	logic pop;

	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_data_out = mem_q[rd_ptr_q];

	// storage, one flop row per entry
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_sys_in) begin
			if (push && wr_ptr_q == PW'(i)) begin
				mem_q[i] <= in_data_in;
			end
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// pointers wrap at depth, so depth need not be a power of two
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			cnt_q <= cnt_d;
			in_ready_out <= cnt_d != CW'(DEPTH);
			out_valid_out <= cnt_d != '0;
		end
	end
endmodule

/* hw/hmap_device.sv */
// Purpose: device end of the host memory access port, in front of the on-chip memory arbiter
// Assumes: pin inputs already synchronous to clk_sys_in; memory answers reads in the cycle of mem_req_out
// Notes: program memory words travel as two bus words, upper 16 bits first, low byte second
`include "hmap_defines.svh"

// Behaviour
// - one stolen memory cycle per word
// - host never writes control register space
// - host checks acknowledge before latching
// - host waits acknowledge between operations
// - 16-bit bus carries 24-bit program words
// - strobes need no processor clock relation; here they are assumed synchronous to clk_sys_in
// - address increments after each completed word
// - address and type latched on latch fall
// - type zero program, one data memory
// - latch only when bus bit 15 low
// - bus bits 0..14 fill control register
// - one sync cycle, one access cycle
// - host never reads back start address
// - processor may write start address register
// - registers at 0x3fe0 and 0x3fe7
// - control register has no reset value
// - boot pins 1,0,1 select port boot
// - port boot holds execution until address 0
module hmap_device (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	hmap_if.device bus,
	input wire logic [2:0] boot_mode_in,
	input wire logic cpu_wr_in,
	input wire logic cpu_rd_in,
	input wire logic [13:0] cpu_addr_in,
	input wire logic [15:0] cpu_wdata_in,
	output logic [15:0] cpu_rdata_out,
	output logic mem_req_out,
	output logic mem_we_out,
	output logic mem_dm_out,
	output logic [13:0] mem_addr_out,
	output logic [23:0] mem_wdata_out,
	input wire logic [23:0] mem_rdata_in,
	output logic run_enable_out
);
	hmap_pkg::dev_state_e state_q;
	logic [13:0] addr_q;
	logic dm_q;
	logic [15:0] ovly_q;
	logic half_q;
	logic [15:0] hold_q;
	logic [7:0] low_q;
	logic [15:0] wdata_q;
	logic is_wr_q;
	logic ale_prev_q;
	logic ack_q;
	logic [15:0] ad_q;
	logic ad_oe_q;
	logic cap_q;
	logic port_boot_q;
	logic sel;
	logic rd_req;
	logic wr_req;
	logic ale_fall;
	logic latch_ok;
	logic cpu_addr_wr;
	logic need_mem;
	logic blocked;
	logic word_done;

	assign bus.access_acknowledge = ack_q;
	assign bus.dev_ad = ad_q;
	assign bus.dev_ad_oe = ad_oe_q;

	// strobes are plain levels here, taken as already synchronous to the processor clock
	assign sel = !bus.port_select_b;
	assign rd_req = sel && !bus.port_read_strobe_b;
	assign wr_req = sel && !bus.port_write_strobe_b;
	assign ale_fall = sel && ale_prev_q && !bus.address_latch_enable;
	assign latch_ok = !bus.multiplexed_addr_data_bus[`HMAP_LATCH_FLAG_BIT];
	assign cpu_addr_wr = cpu_wr_in && cpu_addr_in == `HMAP_START_ADDR_OFS;
	// a program word needs memory only on its complete half: write low byte, read upper word
	assign need_mem = dm_q || (is_wr_q ? half_q : !half_q);
	assign blocked = is_wr_q && dm_q && addr_q >= `HMAP_CTRL_BASE;
	assign word_done = state_q == hmap_pkg::D_ACCESS && (dm_q || half_q);

	// latch enable history for falling edge detection
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ale_prev_q <= 1'b0;
		end else begin
			ale_prev_q <= bus.address_latch_enable;
		end
	end

	// port sequencing: request, sync cycle, access cycle, wait for strobe release
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= hmap_pkg::D_IDLE;
			ack_q <= 1'b1;
			is_wr_q <= 1'b0;
			wdata_q <= 16'h0000;
		end else begin
			unique case (state_q)
				hmap_pkg::D_IDLE: begin
					if (ale_fall) begin
						state_q <= hmap_pkg::D_LATCH;
						ack_q <= 1'b0;
					end else if (rd_req || wr_req) begin
						state_q <= hmap_pkg::D_SYNC;
						ack_q <= 1'b0;
						is_wr_q <= wr_req;
						wdata_q <= bus.multiplexed_addr_data_bus;
					end
				end
				hmap_pkg::D_LATCH: begin
					state_q <= hmap_pkg::D_IDLE;
					ack_q <= 1'b1;
				end
				hmap_pkg::D_SYNC: begin
					state_q <= hmap_pkg::D_ACCESS;
				end
				hmap_pkg::D_ACCESS: begin
					state_q <= hmap_pkg::D_HOLD;
					ack_q <= 1'b1;
				end
				hmap_pkg::D_HOLD: begin
					// a held strobe must not start a second transfer
					if (!rd_req && !wr_req) begin
						state_q <= hmap_pkg::D_IDLE;
					end
				end
			endcase
		end
	end

	// memory request: raised on leaving sync, stands for exactly the access cycle
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_req_out <= 1'b0;
			mem_we_out <= 1'b0;
			mem_dm_out <= 1'b0;
			mem_addr_out <= 14'h0000;
			mem_wdata_out <= 24'h000000;
		end else if (state_q == hmap_pkg::D_SYNC) begin
			mem_req_out <= need_mem && !blocked;
			mem_we_out <= is_wr_q;
			mem_dm_out <= dm_q;
			mem_addr_out <= addr_q;
			mem_wdata_out <= dm_q ? {8'h00, wdata_q} : {hold_q, wdata_q[7:0]};
		end else begin
			mem_req_out <= 1'b0;
		end
	end

	// start address and type; deliberately without reset, its value is undefined until written
	always_ff @(posedge clk_sys_in) begin
		if (state_q == hmap_pkg::D_IDLE && ale_fall && latch_ok) begin
			addr_q <= bus.multiplexed_addr_data_bus[`HMAP_ADDR_MSB:0];
			dm_q <= bus.multiplexed_addr_data_bus[`HMAP_DEST_BIT];
		end else if (cpu_addr_wr) begin
			addr_q <= cpu_wdata_in[`HMAP_ADDR_MSB:0];
			dm_q <= cpu_wdata_in[`HMAP_DEST_BIT];
		end else if (word_done) begin
			addr_q <= addr_q + 1'b1;
		end
	end

	// overlay selection, processor side only, also left without reset
	always_ff @(posedge clk_sys_in) begin
		if (cpu_wr_in && cpu_addr_in == `HMAP_OVERLAY_OFS) begin
			ovly_q <= cpu_wdata_in;
		end
	end

	// program word pairing: which half comes next, and the parked bytes
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			half_q <= 1'b0;
			hold_q <= 16'h0000;
			low_q <= 8'h00;
		end else if ((state_q == hmap_pkg::D_IDLE && ale_fall && latch_ok) || cpu_addr_wr) begin
			half_q <= 1'b0; // a new start address always begins with the upper part
		end else if (state_q == hmap_pkg::D_ACCESS && dm_q == `HMAP_DEST_PM) begin
			half_q <= !half_q;
			if (is_wr_q && !half_q) begin
				hold_q <= wdata_q;
			end
			if (!is_wr_q && !half_q) begin
				low_q <= mem_rdata_in[7:0];
			end
		end
	end

	// read data onto the bus; only memory contents ever go out, never the start address
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ad_q <= 16'h0000;
			ad_oe_q <= 1'b0;
		end else if (state_q == hmap_pkg::D_ACCESS && !is_wr_q) begin
			ad_oe_q <= 1'b1;
			if (dm_q) begin
				ad_q <= mem_rdata_in[15:0];
			end else if (!half_q) begin
				ad_q <= mem_rdata_in[23:8];
			end else begin
				ad_q <= {8'h00, low_q};
			end
		end else if (!rd_req) begin
			ad_oe_q <= 1'b0; // let go as soon as the host lifts its read strobe
		end
	end

	// processor register reads
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cpu_rdata_out <= 16'h0000;
		end else if (cpu_rd_in) begin
			if (cpu_addr_in == `HMAP_START_ADDR_OFS) begin
				cpu_rdata_out <= {1'b0, dm_q, addr_q};
			end else if (cpu_addr_in == `HMAP_OVERLAY_OFS) begin
				cpu_rdata_out <= ovly_q;
			end else begin
				cpu_rdata_out <= 16'h0000;
			end
		end
	end

	// boot pins caught on the first clock after reset release, not by the reset itself
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cap_q <= 1'b0;
			port_boot_q <= 1'b0;
		end else if (!cap_q) begin
			cap_q <= 1'b1;
			port_boot_q <= boot_mode_in == `HMAP_BOOT_PORT;
		end
	end

	// execution hold-off for port boot, released by the program memory write to word zero
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run_enable_out <= 1'b0;
		end else if (cap_q && !port_boot_q) begin
			run_enable_out <= 1'b1;
		end else if (cap_q && mem_req_out && mem_we_out && !mem_dm_out && mem_addr_out == 14'h0000) begin
			run_enable_out <= 1'b1;
		end
	end
endmodule

/* hw/hmap_host.sv */
// Purpose: host end of the host memory access port, driven by software through four registers
// Assumes: device acknowledge is synchronous to clk_sys_in
// Notes: write words queue in a FIFO; a full FIFO drops further data writes, status shows it
`include "hmap_defines.svh"

module hmap_host #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	hmap_if.host bus,
	input wire logic [1:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	output logic wfifo_ready_out
);
	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("hmap_host fifo depth must be at least two");
	end

	hmap_pkg::host_state_e state_q;
	logic saw_low_q;
	logic latch_pend_q;
	logic [15:0] latch_val_q;
	logic read_pend_q;
	logic [15:0] rword_q;
	logic sel_b_q;
	logic ale_q;
	logic rd_b_q;
	logic wr_b_q;
	logic [15:0] ad_q;
	logic ad_oe_q;
	logic fifo_push;
	logic fifo_valid;
	logic [15:0] fifo_data;
	logic go_latch;
	logic go_write;
	logic go_read;

	assign bus.port_select_b = sel_b_q;
	assign bus.address_latch_enable = ale_q;
	assign bus.port_read_strobe_b = rd_b_q;
	assign bus.port_write_strobe_b = wr_b_q;
	assign bus.host_ad = ad_q;
	assign bus.host_ad_oe = ad_oe_q;

	assign fifo_push = reg_wr_in && reg_addr_in == `HREG_DATA;
	// a new operation only starts while the device acknowledges
	assign go_latch = state_q == hmap_pkg::H_IDLE && bus.access_acknowledge && latch_pend_q;
	assign go_write = state_q == hmap_pkg::H_IDLE && bus.access_acknowledge && !latch_pend_q && fifo_valid;
	assign go_read = state_q == hmap_pkg::H_IDLE && bus.access_acknowledge && !latch_pend_q && !fifo_valid
		&& read_pend_q;

	word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wfifo (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(fifo_push),
		.in_ready_out(wfifo_ready_out),
		.in_data_in(reg_wdata_in),
		.out_valid_out(fifo_valid),
		.out_ready_in(go_write),
		.out_data_out(fifo_data)
	);

	// pending commands; a software set in the launch cycle survives the clear
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			latch_pend_q <= 1'b0;
			latch_val_q <= 16'h0000;
			read_pend_q <= 1'b0;
		end else begin
			if (go_latch) begin
				latch_pend_q <= 1'b0;
			end
			if (go_read) begin
				read_pend_q <= 1'b0;
			end
			if (reg_wr_in && reg_addr_in == `HREG_ADDR) begin
				latch_pend_q <= 1'b1;
				latch_val_q <= {1'b0, reg_wdata_in[14:0]};
			end
			if (reg_wr_in && reg_addr_in == `HREG_CMD && reg_wdata_in[`HREG_CMD_READ_BIT]) begin
				read_pend_q <= 1'b1;
			end
		end
	end

	// pin sequencing
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= hmap_pkg::H_IDLE;
			saw_low_q <= 1'b0;
			sel_b_q <= 1'b1;
			ale_q <= 1'b0;
			rd_b_q <= 1'b1;
			wr_b_q <= 1'b1;
			ad_q <= 16'h0000;
			ad_oe_q <= 1'b0;
			rword_q <= 16'h0000;
		end else begin
			unique case (state_q)
				hmap_pkg::H_IDLE: begin
					saw_low_q <= 1'b0;
					if (go_latch) begin
						state_q <= hmap_pkg::H_ALE_HI;
						sel_b_q <= 1'b0;
						ale_q <= 1'b1;
						ad_q <= latch_val_q;
						ad_oe_q <= 1'b1;
					end else if (go_write) begin
						state_q <= hmap_pkg::H_XFER;
						sel_b_q <= 1'b0;
						wr_b_q <= 1'b0;
						ad_q <= fifo_data;
						ad_oe_q <= 1'b1;
					end else if (go_read) begin
						state_q <= hmap_pkg::H_XFER;
						sel_b_q <= 1'b0;
						rd_b_q <= 1'b0;
					end
				end
				hmap_pkg::H_ALE_HI: begin
					state_q <= hmap_pkg::H_ALE_LO;
					ale_q <= 1'b0; // falling edge carries the latch
				end
				hmap_pkg::H_ALE_LO: begin
					state_q <= hmap_pkg::H_WAIT;
					sel_b_q <= 1'b1;
					ad_oe_q <= 1'b0;
				end
				hmap_pkg::H_XFER: begin
					// strobes stay low until the device has dropped and raised acknowledge
					if (!bus.access_acknowledge) begin
						saw_low_q <= 1'b1;
					end else if (saw_low_q) begin
						state_q <= hmap_pkg::H_IDLE;
						sel_b_q <= 1'b1;
						rd_b_q <= 1'b1;
						wr_b_q <= 1'b1;
						ad_oe_q <= 1'b0;
						if (!rd_b_q) begin
							rword_q <= bus.multiplexed_addr_data_bus;
						end
					end
				end
				hmap_pkg::H_WAIT: begin
					if (!bus.access_acknowledge) begin
						saw_low_q <= 1'b1;
					end else if (saw_low_q) begin
						state_q <= hmap_pkg::H_IDLE;
					end
				end
			endcase
		end
	end

	// register reads, one cycle after the strobe
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				`HREG_ADDR: reg_rdata_out <= latch_val_q;
				`HREG_DATA: reg_rdata_out <= rword_q;
				`HREG_CMD: reg_rdata_out <= {15'h0000, read_pend_q};
				`HREG_STAT: reg_rdata_out <= {12'h000, bus.access_acknowledge, !fifo_valid, !wfifo_ready_out,
					state_q != hmap_pkg::H_IDLE || latch_pend_q || read_pend_q || fifo_valid};
			endcase
		end
	end
endmodule

/* sim/hmap_monitor.sv */
// Purpose: pin-level checks on the wires between host and device ends
// Assumes: one clock domain, reset asynchronous active low
// Notes: instantiated beside the interface; sees only interface signals
module hmap_monitor (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic port_select_b,
	input wire logic address_latch_enable,
	input wire logic port_read_strobe_b,
	input wire logic port_write_strobe_b,
	input wire logic access_acknowledge,
	input wire logic host_ad_oe,
	input wire logic dev_ad_oe,
	input wire hmap_pkg::bus_word_t multiplexed_addr_data_bus
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_b_in);

	// data transfers: one sync cycle, one access cycle, then ready again
	a_write_ack_two: assert property (
		!port_select_b && $fell(port_write_strobe_b) |=> !access_acknowledge [*2] ##1 access_acknowledge)
		else $error("write acknowledge timing off");
	a_read_ack_two: assert property (
		!port_select_b && $fell(port_read_strobe_b) |=> !access_acknowledge [*2] ##1 access_acknowledge)
		else $error("read acknowledge timing off");
	// a latch costs one busy cycle after the latch enable falls
	a_latch_ack_one: assert property (
		!port_select_b && $fell(address_latch_enable) |=> !access_acknowledge ##1 access_acknowledge)
		else $error("latch acknowledge timing off");
	a_ack_low_bounded: assert property ($fell(access_acknowledge) |-> ##[1:2] access_acknowledge)
		else $error("acknowledge held low too long");
	// read data must already sit on the bus when ready returns
	a_read_data_out: assert property ($rose(access_acknowledge) && !port_read_strobe_b |-> dev_ad_oe)
		else $error("read data not driven at completion");
	a_read_oe_drop: assert property ($rose(port_read_strobe_b) |=> !dev_ad_oe)
		else $error("device kept driving after read released");
	a_no_bus_fight: assert property (!(host_ad_oe && dev_ad_oe))
		else $error("both ends drive the shared bus");
	a_start_on_ack: assert property (
		($fell(port_write_strobe_b) || $fell(port_read_strobe_b) || $rose(address_latch_enable)) |-> access_acknowledge)
		else $error("host started while device busy");
	a_latch_bit_low: assert property (
		address_latch_enable && !port_select_b |-> host_ad_oe && !multiplexed_addr_data_bus[15])
		else $error("latch cycle without bit 15 low");
	// one released select cycle is enough between operations; the next may start right after it
	a_select_gap: assert property (
		($fell(port_write_strobe_b) || $fell(port_read_strobe_b) || $rose(address_latch_enable)) |-> $past(port_select_b))
		else $error("no released cycle between operations");

	c_write: cover property (!port_select_b && $fell(port_write_strobe_b));
	c_read: cover property (!port_select_b && $fell(port_read_strobe_b));
	c_latch: cover property (!port_select_b && $fell(address_latch_enable));
endmodule

/* sim/host_memory_access_port_bench.sv */
// Purpose: drives the host registers and the processor port, checks on-chip memory effects
// Assumes: port boot mode; memory modelled here and answers in the request cycle
// Notes: accepted burst words are tracked from the FIFO ready flag sampled mid-cycle before each push edge
`include "hmap_defines.svh"

module host_memory_access_port_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic wfifo_ready_out;
	logic cpu_wr = 1'b0;
	logic cpu_rd = 1'b0;
	logic [13:0] cpu_addr = 14'h0000;
	logic [15:0] cpu_wdata = 16'h0000;
	logic [15:0] cpu_rdata;
	logic mem_req, mem_we, mem_dm, run_enable_out;
	logic [13:0] mem_addr;
	logic [23:0] mem_wdata;
	logic [23:0] store [0:32767];
	int failures = 0;
	int compares = 0;
	int mem_writes = 0;
	logic [15:0] v;
	logic [15:0] q [$];
	logic [15:0] pm_exp [4] = '{16'habcd, 16'h00ef, 16'h1234, 16'h0056};

	always #5 clk_sys_in = ~clk_sys_in;

	hmap_if u_hmap_if ();
	hmap_device u_hmap_device (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus(u_hmap_if),
		.boot_mode_in(3'h5), .cpu_wr_in(cpu_wr), .cpu_rd_in(cpu_rd), .cpu_addr_in(cpu_addr),
		.cpu_wdata_in(cpu_wdata), .cpu_rdata_out(cpu_rdata), .mem_req_out(mem_req), .mem_we_out(mem_we),
		.mem_dm_out(mem_dm), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
		.mem_rdata_in(store[{mem_dm, mem_addr}]), .run_enable_out(run_enable_out));
	hmap_host #(.FIFO_DEPTH(8)) u_hmap_host (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .bus(u_hmap_if),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .wfifo_ready_out(wfifo_ready_out));
	hmap_monitor u_hmap_monitor (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.port_select_b(u_hmap_if.port_select_b), .address_latch_enable(u_hmap_if.address_latch_enable),
		.port_read_strobe_b(u_hmap_if.port_read_strobe_b), .port_write_strobe_b(u_hmap_if.port_write_strobe_b),
		.access_acknowledge(u_hmap_if.access_acknowledge), .host_ad_oe(u_hmap_if.host_ad_oe),
		.dev_ad_oe(u_hmap_if.dev_ad_oe), .multiplexed_addr_data_bus(u_hmap_if.multiplexed_addr_data_bus));

	// on-chip memory stand-in; counts every stolen write cycle
	always @(posedge clk_sys_in) begin
		if (mem_req === 1'b1 && mem_we === 1'b1) begin
			store[{mem_dm, mem_addr}] <= mem_wdata;
			mem_writes <= mem_writes + 1;
		end
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// one host register cycle; read data taken in the cycle after the strobe
	task automatic reg_acc(input logic w, input logic [1:0] a, input logic [15:0] d, output logic [15:0] r);
		@(posedge clk_sys_in);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask

	// one processor register cycle, same shape as the host side
	task automatic cpu_acc(input logic w, input logic [13:0] a, input logic [15:0] d, output logic [15:0] r);
		@(posedge clk_sys_in);
		cpu_wr <= w;
		cpu_rd <= !w;
		cpu_addr <= a;
		cpu_wdata <= d;
		@(posedge clk_sys_in);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b0;
		#1 r = cpu_rdata;
	endtask

	// poll status until not busy and FIFO empty; a stuck port ends the run
	task automatic wait_idle();
		logic [15:0] s;
		int n;
		repeat (3) @(posedge clk_sys_in);
		for (n = 0; n < 300; n++) begin
			reg_acc(1'b0, `HREG_STAT, 16'h0000, s);
			if (s[`HREG_STAT_BUSY_BIT] === 1'b0 && s[`HREG_STAT_EMPTY_BIT] === 1'b1) break;
		end
		if (n == 300) begin
			failures++;
			end_sim();
		end
	endtask

	initial begin
		#300000;
		failures++;
		end_sim();
	end

	initial begin
		store[{1'b1, 14'h3fe0}] = 24'h00a5a5;
		repeat (3) @(posedge clk_sys_in);
		check(u_hmap_if.multiplexed_addr_data_bus, 16'hffff);
		check({u_hmap_if.access_acknowledge, wfifo_ready_out, run_enable_out}, 3'h6);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		reg_acc(1'b0, `HREG_STAT, 16'h0000, v);
		check(v[3:0], 4'hc);
		// a program word at address 1 must not release execution
		reg_acc(1'b1, `HREG_ADDR, 16'h0001, v);
		reg_acc(1'b1, `HREG_DATA, pm_exp[2], v);
		reg_acc(1'b1, `HREG_DATA, pm_exp[3], v);
		wait_idle();
		check(run_enable_out, 1'b0);
		reg_acc(1'b1, `HREG_ADDR, 16'h0000, v);
		reg_acc(1'b1, `HREG_DATA, pm_exp[0], v);
		reg_acc(1'b1, `HREG_DATA, pm_exp[1], v);
		wait_idle();
		check(run_enable_out, 1'b1);
		check(store[0], 24'habcdef);
		check(store[1], 24'h123456);
		check(mem_writes, 2);
		// read back across the word boundary with one latch only
		reg_acc(1'b1, `HREG_ADDR, 16'h0000, v);
		for (int i = 0; i < 4; i++) begin
			reg_acc(1'b1, `HREG_CMD, 16'h0001, v);
			wait_idle();
			reg_acc(1'b0, `HREG_DATA, 16'h0000, v);
			check(v, pm_exp[i]);
		end
		// back-to-back data burst overruns the FIFO while the port drains it
		reg_acc(1'b1, `HREG_ADDR, 16'h4010, v);
		@(posedge clk_sys_in);
		reg_addr <= `HREG_DATA;
		reg_wr <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			reg_wdata <= 16'h0a00 + 16'(i);
			// ready is looked at mid-cycle, where it is settled for the coming push edge
			@(negedge clk_sys_in);
			if (wfifo_ready_out === 1'b1) q.push_back(16'h0a00 + 16'(i));
			@(posedge clk_sys_in);
		end
		reg_wr <= 1'b0;
		check(q.size() < 12, 1'b1);
		wait_idle();
		foreach (q[j]) check(store[{1'b1, 14'h0010 + 14'(j)}][15:0], q[j]);
		reg_acc(1'b1, `HREG_ADDR, 16'h4010, v);
		for (int i = 0; i < 2; i++) begin
			reg_acc(1'b1, `HREG_CMD, 16'h0001, v);
			wait_idle();
			reg_acc(1'b0, `HREG_DATA, 16'h0000, v);
			check(v, q[i]);
		end
		// control register space is never written from the host
		reg_acc(1'b1, `HREG_ADDR, 16'h7fe0, v);
		reg_acc(1'b1, `HREG_DATA, 16'h1234, v);
		wait_idle();
		check(store[{1'b1, 14'h3fe0}], 24'h00a5a5);
		// processor sets the start address, host data follows it
		cpu_acc(1'b1, 14'h3fe0, 16'h4020, v);
		reg_acc(1'b1, `HREG_DATA, 16'h5a5a, v);
		wait_idle();
		check(store[{1'b1, 14'h0020}][15:0], 16'h5a5a);
		cpu_acc(1'b0, 14'h3fe0, 16'h0000, v);
		check(v, 16'h4021);
		cpu_acc(1'b1, 14'h3fe7, 16'h0002, v);
		cpu_acc(1'b0, 14'h3fe7, 16'h0000, v);
		check(v, 16'h0002);
		end_sim();
	end
endmodule
